// [core/accel_rate_pkg.sv]
// ****************************************************************
// Shared constants for the accelerometer rate and FIFO select block
// ****************************************************************
package accel_rate_pkg;
   // Register offsets on the serial register interface
   localparam logic [7:0] OFS_WAKE_RATE = 8'h1e;
   localparam logic [7:0] OFS_WAKE_LEVEL = 8'h1f;
   localparam logic [7:0] OFS_FIFO_EN = 8'h23;
   // Reset values
   localparam logic [3:0] RST_WAKE_RATE = 4'h0;
   localparam logic [7:0] RST_WAKE_LEVEL = 8'h00;
   localparam logic [7:0] RST_FIFO_EN = 8'h00;
   // Field positions in the FIFO enable register
   localparam int EN_TEMP_BIT = 7;
   localparam int EN_RATE_X_BIT = 6;
   localparam int EN_RATE_Y_BIT = 5;
   localparam int EN_RATE_Z_BIT = 4;
   localparam int EN_ACCEL_BIT = 3;
   localparam int EN_SLOT2_BIT = 2;
   localparam int EN_SLOT1_BIT = 1;
   localparam int EN_SLOT0_BIT = 0;
   // Wake rate field width and highest usable code
   localparam int WAKE_RATE_W = 4;
   localparam logic [3:0] WAKE_RATE_MAX = 4'hb;
   // Timing
   localparam int CLK_HZ = 250_000_000;
   localparam int RATE_BYPASS_HZ = 4000;
   localparam int RATE_FILTER_HZ = 1000;
   localparam int LP_TOP_HZ = 500;
   localparam int LP_DELAY_MS = 1;
   localparam int RATE_BYPASS_CYC = CLK_HZ / RATE_BYPASS_HZ;
   localparam int RATE_FILTER_CYC = CLK_HZ / RATE_FILTER_HZ;
   localparam int LP_TOP_CYC = CLK_HZ / LP_TOP_HZ;
   localparam int LP_DELAY_CYC = (CLK_HZ / 1000) * LP_DELAY_MS;
   // Threshold scale
   localparam int WAKE_LEVEL_MG_PER_STEP = 4;
   localparam int COUNTS_PER_STEP = 65;
   // Byte layout of the captured sample
   localparam int INT_BYTES = 14;
   localparam int EXT_BYTES = 24;
   localparam int SNAP_BYTES = INT_BYTES + EXT_BYTES;
   localparam logic [2:0] SRC_LAST = 3'h7;
endpackage

// [core/pair_buffer.sv]
`timescale 1ns/1ps
// ****************************************************************
// Two-entry buffer, both outputs straight from flip-flops
// ****************************************************************
module pair_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic out_valid_q, out_valid_d; // Head entry occupied
   logic [WIDTH-1:0] out_q, out_d; // Head entry
   logic spare_valid_q, spare_valid_d; // Second entry occupied
   logic [WIDTH-1:0] spare_q, spare_d; // Second entry
   logic push, pop;

   // Next state of the two entries
   always_comb begin
      push = in_valid && !spare_valid_q;
      pop = out_valid_q && out_ready;
      out_valid_d = out_valid_q;
      out_d = out_q;
      spare_valid_d = spare_valid_q;
      spare_d = spare_q;
      if (!out_valid_q || pop) begin
         // Head is free this cycle
         if (spare_valid_q) begin
            out_d = spare_q;
            out_valid_d = 1'b1;
            spare_valid_d = push;
            spare_d = in_data;
         end else begin
            out_valid_d = push;
            out_d = in_data;
         end
      end else if (push) begin
         // Head stalled, park the word
         spare_valid_d = 1'b1;
         spare_d = in_data;
      end
   end

   // Register the entries
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid_q <= 1'b0;
         out_q <= '0;
         spare_valid_q <= 1'b0;
         spare_q <= '0;
      end else begin
         out_valid_q <= out_valid_d;
         out_q <= out_d;
         spare_valid_q <= spare_valid_d;
         spare_q <= spare_d;
      end
   end

   assign in_ready = !spare_valid_q;
   assign out_valid = out_valid_q;
   assign out_data = out_q;
endmodule

// [core/accel_rate_wom_fifo_select.sv]
`timescale 1ns/1ps
// Overview of operation
// - Bypass gives 4 kHz, filter gives 1 kHz
// - Divide filtered rate by one plus divider
// - Low-power duty-cycles, filter choice forced zero
// - Low-power output fixed wide band, 1 ms delay
// - Four-bit code sets low-power wake rate
// - Compare axis motion against threshold, raise wake
// - Threshold step is 4 mg, up to 1020
// - Temperature bytes pushed when its enable set
// - Each gyro axis pushed when enabled
// - Enabled sources pushed even in standby
// - Accel pushes six bytes x, y, z
// - External slots pushed at offsets from lengths
// - Bypass bit and setting select normal filter
module accel_rate_wom_fifo_select #(
   parameter int RATE_BYPASS_CYC = accel_rate_pkg::RATE_BYPASS_CYC,
   parameter int RATE_FILTER_CYC = accel_rate_pkg::RATE_FILTER_CYC,
   parameter int LP_TOP_CYC = accel_rate_pkg::LP_TOP_CYC,
   parameter int LP_DELAY_CYC = accel_rate_pkg::LP_DELAY_CYC,
   parameter int COUNTS_PER_STEP = accel_rate_pkg::COUNTS_PER_STEP
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic low_power_mode,
   input wire logic lin_filter_bypass,
   input wire logic [2:0] lin_lowpass_setting,
   input wire logic [7:0] sample_divider,
   input wire logic [15:0] temp_word,
   input wire logic [15:0] rate_x_word,
   input wire logic [15:0] rate_y_word,
   input wire logic [15:0] rate_z_word,
   input wire logic [15:0] accel_x_word,
   input wire logic [15:0] accel_y_word,
   input wire logic [15:0] accel_z_word,
   input wire logic [8*accel_rate_pkg::EXT_BYTES-1:0] external_sensor_bytes,
   input wire logic [3:0] slot0_len,
   input wire logic [3:0] slot1_len,
   input wire logic [3:0] slot2_len,
   output logic lin_filter_choice,
   output logic [2:0] lowpass_setting_out,
   output logic lp_fixed_band,
   output logic accel_awake,
   output logic sample_strobe,
   output logic wom_event,
   output logic fifo_valid,
   input wire logic fifo_ready,
   output logic [7:0] fifo_byte
);
   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // Low-power wake period in cycles, reserved codes held at the top
   function automatic logic [31:0] lp_period(input logic [3:0] code);
      logic [3:0] c;
      c = (code > accel_rate_pkg::WAKE_RATE_MAX) ? accel_rate_pkg::WAKE_RATE_MAX : code;
      lp_period = 32'(LP_TOP_CYC) << (accel_rate_pkg::WAKE_RATE_MAX - c);
   endfunction

   // Byte count of one source, zero when disabled
   function automatic logic [3:0] src_len(input logic [2:0] s, input logic [7:0] en,
                                          input logic [3:0] l0, input logic [3:0] l1,
                                          input logic [3:0] l2);
      case (s)
         3'h0: src_len = en[accel_rate_pkg::EN_TEMP_BIT] ? 4'h2 : 4'h0;
         3'h1: src_len = en[accel_rate_pkg::EN_RATE_X_BIT] ? 4'h2 : 4'h0;
         3'h2: src_len = en[accel_rate_pkg::EN_RATE_Y_BIT] ? 4'h2 : 4'h0;
         3'h3: src_len = en[accel_rate_pkg::EN_RATE_Z_BIT] ? 4'h2 : 4'h0;
         3'h4: src_len = en[accel_rate_pkg::EN_ACCEL_BIT] ? 4'h6 : 4'h0;
         3'h5: src_len = en[accel_rate_pkg::EN_SLOT0_BIT] ? l0 : 4'h0;
         3'h6: src_len = en[accel_rate_pkg::EN_SLOT1_BIT] ? l1 : 4'h0;
         default: src_len = en[accel_rate_pkg::EN_SLOT2_BIT] ? l2 : 4'h0;
      endcase
   endfunction

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   logic [3:0] rate_q, rate_d; // Low-power wake rate code
   logic [7:0] level_q, level_d; // Motion wake level
   logic [7:0] en_q, en_d; // FIFO source enables
   logic [7:0] rdata_q, rdata_d; // Read data

   // Register writes and read mux
   always_comb begin
      rate_d = rate_q;
      level_d = level_q;
      en_d = en_q;
      rdata_d = rdata_q;
      if (reg_wr) begin
         case (reg_addr)
            accel_rate_pkg::OFS_WAKE_RATE: rate_d = reg_wdata[3:0]; // Upper bits dropped
            accel_rate_pkg::OFS_WAKE_LEVEL: level_d = reg_wdata;
            accel_rate_pkg::OFS_FIFO_EN: en_d = reg_wdata; // No fourth slot bit
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            accel_rate_pkg::OFS_WAKE_RATE: rdata_d = {4'h0, rate_q};
            accel_rate_pkg::OFS_WAKE_LEVEL: rdata_d = level_q;
            accel_rate_pkg::OFS_FIFO_EN: rdata_d = en_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Register the configuration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rate_q <= accel_rate_pkg::RST_WAKE_RATE;
         level_q <= accel_rate_pkg::RST_WAKE_LEVEL;
         en_q <= accel_rate_pkg::RST_FIFO_EN;
         rdata_q <= 8'h00;
      end else begin
         rate_q <= rate_d;
         level_q <= level_d;
         en_q <= en_d;
         rdata_q <= rdata_d;
      end
   end

   // ****************************************************************
   // Rate generation
   // ****************************************************************
   logic [31:0] base_cnt_q, base_cnt_d; // Filter output period counter
   logic [7:0] div_cnt_q, div_cnt_d; // Sample divider counter
   logic [31:0] lp_cnt_q, lp_cnt_d; // Low-power wake counter
   logic [31:0] dly_cnt_q, dly_cnt_d; // Low-power settle counter
   logic awake_q, awake_d; // Accel powered
   logic strobe_q, strobe_d; // Sample-rate strobe
   logic choice_q, choice_d; // Filter in use
   logic [2:0] setting_q, setting_d;
   logic fixed_q, fixed_d; // Low-power fixed band
   logic [31:0] base_top;

   // Next values of the rate logic
   always_comb begin
      base_top = lin_filter_bypass ? 32'(RATE_BYPASS_CYC - 1) : 32'(RATE_FILTER_CYC - 1);
      base_cnt_d = base_cnt_q;
      div_cnt_d = div_cnt_q;
      lp_cnt_d = lp_cnt_q;
      dly_cnt_d = dly_cnt_q;
      awake_d = awake_q;
      strobe_d = 1'b0;
      choice_d = !lin_filter_bypass;
      setting_d = lin_lowpass_setting;
      fixed_d = 1'b0;
      if (!low_power_mode) begin
         awake_d = 1'b1;
         lp_cnt_d = lp_period(rate_q) - 32'h0000_0001;
         if (base_cnt_q >= base_top) begin
            base_cnt_d = 32'h0000_0000;
            if (div_cnt_q >= sample_divider) begin
               div_cnt_d = 8'h00;
               strobe_d = 1'b1;
            end else begin
               div_cnt_d = div_cnt_q + 8'h01;
            end
         end else begin
            base_cnt_d = base_cnt_q + 32'h0000_0001;
         end
      end else begin
         choice_d = 1'b0;
         fixed_d = 1'b1;
         base_cnt_d = 32'h0000_0000;
         div_cnt_d = 8'h00;
         if (awake_q) begin
            // Settle before the sample is taken
            if (dly_cnt_q == 32'h0000_0000) begin
               awake_d = 1'b0;
               strobe_d = 1'b1;
            end else begin
               dly_cnt_d = dly_cnt_q - 32'h0000_0001;
            end
         end
         if (lp_cnt_q == 32'h0000_0000) begin
            lp_cnt_d = lp_period(rate_q) - 32'h0000_0001;
            awake_d = 1'b1;
            dly_cnt_d = 32'(LP_DELAY_CYC - 1);
         end else begin
            lp_cnt_d = lp_cnt_q - 32'h0000_0001;
         end
      end
   end

   // Register the rate logic
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         base_cnt_q <= 32'h0000_0000;
         div_cnt_q <= 8'h00;
         lp_cnt_q <= 32'h0000_0000;
         dly_cnt_q <= 32'h0000_0000;
         awake_q <= 1'b0;
         strobe_q <= 1'b0;
         choice_q <= 1'b0;
         setting_q <= 3'h0;
         fixed_q <= 1'b0;
      end else begin
         base_cnt_q <= base_cnt_d;
         div_cnt_q <= div_cnt_d;
         lp_cnt_q <= lp_cnt_d;
         dly_cnt_q <= dly_cnt_d;
         awake_q <= awake_d;
         strobe_q <= strobe_d;
         choice_q <= choice_d;
         setting_q <= setting_d;
         fixed_q <= fixed_d;
      end
   end

   // ****************************************************************
   // Motion wake compare and FIFO sequencer
   // ****************************************************************
   logic [15:0] prev_q [0:2], prev_d [0:2]; // Last accel sample
   logic wom_q, wom_d;
   logic [7:0] snap_q [0:accel_rate_pkg::SNAP_BYTES-1], snap_d [0:accel_rate_pkg::SNAP_BYTES-1];
   logic busy_q, busy_d;
   logic [2:0] src_q, src_d; // Current source
   logic [3:0] idx_q, idx_d; // Byte within source
   logic [3:0] cur_len;
   logic [5:0] addr;
   logic push_valid, push_ready;
   logic [15:0] now [0:2];
   logic [16:0] diff;
   logic [16:0] mag;
   logic [16:0] limit;

   // Next values of the compare and sequencer
   always_comb begin
      now[0] = accel_x_word;
      now[1] = accel_y_word;
      now[2] = accel_z_word;
      limit = 17'(level_q * COUNTS_PER_STEP); // 4 mg per step
      prev_d = prev_q;
      wom_d = 1'b0;
      snap_d = snap_q;
      busy_d = busy_q;
      src_d = src_q;
      idx_d = idx_q;
      diff = 17'h0_0000;
      mag = 17'h0_0000;
      cur_len = src_len(src_q, en_q, slot0_len, slot1_len, slot2_len);
      // Slot bytes start after the lower slots' bytes
      case (src_q)
         3'h5: addr = 6'(accel_rate_pkg::INT_BYTES) + 6'(idx_q);
         3'h6: addr = 6'(accel_rate_pkg::INT_BYTES) + 6'(slot0_len) + 6'(idx_q);
         3'h7: addr = 6'(accel_rate_pkg::INT_BYTES) + 6'(slot0_len) + 6'(slot1_len) + 6'(idx_q);
         default: addr = {2'b00, src_q, 1'b0} + 6'(idx_q);
      endcase
      if (addr > 6'(accel_rate_pkg::SNAP_BYTES - 1)) begin
         addr = 6'(accel_rate_pkg::SNAP_BYTES - 1);
      end
      push_valid = busy_q && (cur_len != 4'h0);
      if (strobe_q) begin
         for (int a = 0; a < 3; a++) begin
            diff = {now[a][15], now[a]} - {prev_q[a][15], prev_q[a]};
            mag = diff[16] ? 17'(-diff) : diff;
            if (mag > limit) begin
               wom_d = 1'b1;
            end
            prev_d[a] = now[a];
         end
      end
      if (!busy_q && strobe_q) begin
         // Capture the whole sample so the pushed bytes agree
         busy_d = 1'b1;
         src_d = 3'h0;
         idx_d = 4'h0;
         snap_d[0] = temp_word[15:8];
         snap_d[1] = temp_word[7:0];
         snap_d[2] = rate_x_word[15:8];
         snap_d[3] = rate_x_word[7:0];
         snap_d[4] = rate_y_word[15:8];
         snap_d[5] = rate_y_word[7:0];
         snap_d[6] = rate_z_word[15:8];
         snap_d[7] = rate_z_word[7:0];
         snap_d[8] = accel_x_word[15:8];
         snap_d[9] = accel_x_word[7:0];
         snap_d[10] = accel_y_word[15:8];
         snap_d[11] = accel_y_word[7:0];
         snap_d[12] = accel_z_word[15:8];
         snap_d[13] = accel_z_word[7:0];
         for (int b = 0; b < accel_rate_pkg::EXT_BYTES; b++) begin
            snap_d[accel_rate_pkg::INT_BYTES + b] = external_sensor_bytes[8*b +: 8];
         end
      end else if (busy_q) begin
         if (cur_len == 4'h0 || (push_ready && idx_q == cur_len - 4'h1)) begin
            // Source done, step in fixed order
            idx_d = 4'h0;
            if (src_q == accel_rate_pkg::SRC_LAST) begin
               busy_d = 1'b0;
            end else begin
               src_d = src_q + 3'h1;
            end
         end else if (push_ready) begin
            idx_d = idx_q + 4'h1;
         end
      end
   end

   // Register the compare and sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int a = 0; a < 3; a++) begin
            prev_q[a] <= 16'h0000;
         end
         for (int b = 0; b < accel_rate_pkg::SNAP_BYTES; b++) begin
            snap_q[b] <= 8'h00;
         end
         wom_q <= 1'b0;
         busy_q <= 1'b0;
         src_q <= 3'h0;
         idx_q <= 4'h0;
      end else begin
         prev_q <= prev_d;
         snap_q <= snap_d;
         wom_q <= wom_d;
         busy_q <= busy_d;
         src_q <= src_d;
         idx_q <= idx_d;
      end
   end

   // Buffer toward the shared FIFO
   pair_buffer #(.WIDTH(8)) u_buf (
      .clk(ref_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(snap_q[addr]),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_byte)
   );

   assign reg_rdata = rdata_q;
   assign lin_filter_choice = choice_q;
   assign lowpass_setting_out = setting_q;
   assign lp_fixed_band = fixed_q;
   assign accel_awake = awake_q;
   assign sample_strobe = strobe_q;
   assign wom_event = wom_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_start;
      strobe_q && !busy_q;
   endsequence
   a_choice_lowpower: assert property (@(posedge ref_clk) disable iff (rst)
      low_power_mode |=> !lin_filter_choice && lp_fixed_band)
      else $error("filter choice not zero in low power");
   a_choice_normal: assert property (@(posedge ref_clk) disable iff (rst)
      !low_power_mode |=> lin_filter_choice == !$past(lin_filter_bypass))
      else $error("filter choice does not follow bypass");
   a_reset_zero: assert property (@(posedge ref_clk)
      rst |=> rate_q == 4'h0 && level_q == 8'h00 && en_q == 8'h00)
      else $error("registers not cleared by reset");
   a_wom_cause: assert property (@(posedge ref_clk) disable iff (rst)
      wom_event |-> $past(strobe_q))
      else $error("motion event without sample");
   a_seq_start: assert property (@(posedge ref_clk) disable iff (rst)
      s_start |=> busy_q && src_q == 3'h0 && idx_q == 4'h0)
      else $error("sequencer did not start at temperature");
   a_order_rising: assert property (@(posedge ref_clk) disable iff (rst)
      busy_q && $past(busy_q) |-> src_q >= $past(src_q))
      else $error("sources pushed out of order");
   a_push_enabled: assert property (@(posedge ref_clk) disable iff (rst)
      push_valid |-> ((src_q < 3'h5) ? en_q[3'h7 - src_q] : en_q[src_q - 3'h5]))
      else $error("disabled source pushed");
   a_level_write: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == accel_rate_pkg::OFS_WAKE_LEVEL |=> level_q == $past(reg_wdata))
      else $error("threshold write lost");
   a_lp_strobe_awake: assert property (@(posedge ref_clk) disable iff (rst)
      strobe_q && $past(low_power_mode) |-> $past(awake_q) && !awake_q)
      else $error("low-power sample without wake");
   a_div_strobe: assert property (@(posedge ref_clk) disable iff (rst)
      strobe_q && !$past(low_power_mode) |-> $past(div_cnt_q) >= $past(sample_divider))
      else $error("sample strobe before divider count");
endmodule

// [bench/byte_sink.sv]
`timescale 1ns/1ps
// ****************************************************************
// Byte stream receiver that can stall
// ****************************************************************
module byte_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic stall_en,
   input wire logic fifo_valid,
   input wire logic [7:0] fifo_byte,
   output logic fifo_ready,
   output logic got,
   output logic [7:0] got_byte
);
   logic [1:0] cnt_q; // Stall pattern phase
   // Free running phase for the stall pattern
   always_ff @(posedge clk) begin
      if (rst) cnt_q <= 2'h0;
      else cnt_q <= cnt_q + 2'h1;
   end
   // Ready one cycle in four while stalling
   assign fifo_ready = !stall_en || (cnt_q == 2'h0);
   assign got = fifo_valid && fifo_ready;
   assign got_byte = fifo_byte;
endmodule

// [bench/accel_rate_wom_fifo_select_test.sv]
`timescale 1ns/1ps
// ****************************************************************
// Bench for rate select, motion wake and FIFO source select
// ****************************************************************
module accel_rate_wom_fifo_select_test;
   logic ref_clk, rst, reg_wr, reg_rd, low_power_mode, lin_filter_bypass, stall_en;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, sample_divider, rd_v, fifo_byte, got_byte;
   logic [2:0] lin_lowpass_setting, lowpass_setting_out;
   logic [15:0] w[7]; // Temp, rate x y z, accel x y z
   logic [8*accel_rate_pkg::EXT_BYTES-1:0] ext_bytes; // External bytes
   logic [3:0] slot0_len, slot1_len, slot2_len;
   logic lin_filter_choice, lp_fixed_band, accel_awake, sample_strobe, wom_event;
   logic fifo_valid, fifo_ready, got;
   logic [7:0] rx_q[$], ex_q[$]; // Received and expected bytes
   int err_count, cmp_count;
   accel_rate_wom_fifo_select #(.RATE_BYPASS_CYC(4), .RATE_FILTER_CYC(8), .LP_TOP_CYC(4),
      .LP_DELAY_CYC(3), .COUNTS_PER_STEP(65)) u_accel_rate_wom_fifo_select (
      .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .low_power_mode(low_power_mode),
      .lin_filter_bypass(lin_filter_bypass), .lin_lowpass_setting(lin_lowpass_setting),
      .sample_divider(sample_divider), .temp_word(w[0]), .rate_x_word(w[1]),
      .rate_y_word(w[2]), .rate_z_word(w[3]), .accel_x_word(w[4]), .accel_y_word(w[5]),
      .accel_z_word(w[6]), .external_sensor_bytes(ext_bytes), .slot0_len(slot0_len),
      .slot1_len(slot1_len), .slot2_len(slot2_len), .lin_filter_choice(lin_filter_choice),
      .lowpass_setting_out(lowpass_setting_out), .lp_fixed_band(lp_fixed_band),
      .accel_awake(accel_awake), .sample_strobe(sample_strobe), .wom_event(wom_event),
      .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_byte(fifo_byte));
   byte_sink u_byte_sink (.clk(ref_clk), .rst(rst), .stall_en(stall_en),
      .fifo_valid(fifo_valid), .fifo_byte(fifo_byte), .fifo_ready(fifo_ready), .got(got),
      .got_byte(got_byte));
   // Clock at 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Collect every accepted byte
   always @(posedge ref_clk) begin
      if (got) rx_q.push_back(got_byte);
   end
   // Verdict and end of run
   task final_report;
      if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Compare one value
   task check(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Count a used-up wait and end the run
   task give_up(input logic hit);
      if (hit) begin
         err_count++;
         final_report();
      end
   endtask
   // Advance n edges, land just after the last one
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   // Register write, one cycle strobe
   task wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   // Register read, data taken just after the strobe edge
   task rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      tick(1);
      reg_rd = 1'b0;
      d = reg_rdata;
      tick(1);
   endtask
   // Wait for a strobe under a bound
   task wait_strobe(input int bound);
      for (int i = 0; i < bound; i++) begin
         tick(1);
         if (sample_strobe === 1'b1) return;
      end
      err_count++;
      final_report();
   endtask
   // Measure cycles between two strobes
   task period(input string nm, input int exp);
      int c;
      // Skip two strobes, the first gap may still follow the old setting
      wait_strobe(10000);
      wait_strobe(10000);
      c = 0;
      do begin
         tick(1);
         c++;
      end while (sample_strobe !== 1'b1 && c < 10000);
      give_up(c >= 10000);
      check(nm, exp, c);
   endtask
   // Reset values, read back, unmapped place
   task t_regs;
      logic [7:0] adr[3];
      logic [7:0] val[3];
      adr = '{accel_rate_pkg::OFS_WAKE_RATE, accel_rate_pkg::OFS_WAKE_LEVEL,
         accel_rate_pkg::OFS_FIFO_EN};
      val = '{8'h0b, 8'hff, 8'h5a}; // Wake code kept below 12
      for (int i = 0; i < 3; i++) begin
         rd(adr[i], rd_v);
         check("reg reset", 8'h00, rd_v);
         wr(adr[i], val[i]);
         rd(adr[i], rd_v);
         check("reg back", val[i], rd_v);
      end
      wr(8'h20, 8'h77);
      rd(8'h20, rd_v);
      check("unmapped", 8'h00, rd_v);
      wr(accel_rate_pkg::OFS_FIFO_EN, 8'h00);
   endtask
   // Normal and low-power rates and filter outputs
   task t_rates;
      int c;
      check("awake normal", 1'b1, accel_awake);
      check("band normal", 1'b0, lp_fixed_band);
      lin_lowpass_setting = 3'h5;
      lin_filter_bypass = 1'b1;
      period("bypass period", 4);
      check("choice bypass", 1'b0, lin_filter_choice);
      check("setting", 3'h5, lowpass_setting_out);
      lin_filter_bypass = 1'b0;
      period("filter period", 8);
      check("choice filter", 1'b1, lin_filter_choice);
      sample_divider = 8'h02;
      period("divided period", 24);
      sample_divider = 8'h00;
      low_power_mode = 1'b1;
      wr(accel_rate_pkg::OFS_WAKE_RATE, 8'h0b);
      period("lp code 11", 4);
      check("choice lp", 1'b0, lin_filter_choice);
      check("fixed band", 1'b1, lp_fixed_band);
      wr(accel_rate_pkg::OFS_WAKE_RATE, 8'h0a);
      period("lp code 10", 8);
      wr(accel_rate_pkg::OFS_WAKE_RATE, 8'h00);
      period("lp code 0", 8192);
      c = 0;
      while (accel_awake !== 1'b1 && c < 9000) begin
         tick(1);
         c++;
      end
      give_up(c >= 9000);
      c = 0;
      do begin
         tick(1);
         c++;
      end while (sample_strobe !== 1'b1 && c < 20);
      give_up(c >= 20);
      check("wake to sample", 3, c);
      check("asleep after sample", 1'b0, accel_awake);
      low_power_mode = 1'b0;
   endtask
   // One strobe's worth of FIFO bytes
   task t_frame(input logic [7:0] en, input logic stall);
      sample_divider = 8'hff;
      stall_en = 1'b0;
      wait_strobe(3000);
      tick(100);
      wr(accel_rate_pkg::OFS_FIFO_EN, en);
      rx_q.delete();
      ex_q.delete();
      stall_en = stall;
      wait_strobe(3000);
      tick(150);
      for (int i = 0; i < 7; i++) begin
         if (en[i < 4 ? 7 - i : 3]) begin
            ex_q.push_back(w[i][15:8]);
            ex_q.push_back(w[i][7:0]);
         end
      end
      for (int i = 0; i < 6; i++) begin
         if (en[i < 2 ? 0 : (i < 5 ? 1 : 2)]) ex_q.push_back(8'(8'h40 + i));
      end
      check("frame length", ex_q.size(), rx_q.size());
      foreach (ex_q[i]) check("frame byte", ex_q[i], rx_q[i]);
   endtask
   // Motion against the threshold on one strobe
   task t_wom(input logic [15:0] dx, input logic [15:0] dz, input logic exp);
      wait_strobe(100);
      tick(2);
      w[4] = w[4] + dx;
      w[6] = w[6] + dz;
      wait_strobe(100);
      tick(1);
      check("motion event", exp, wom_event);
   endtask
   // Main sequence
   initial begin
      {rst, reg_wr, reg_rd, low_power_mode, lin_filter_bypass, stall_en} = 6'h20;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      lin_lowpass_setting = 3'h0;
      sample_divider = 8'h00;
      w = '{16'h1011, 16'h2122, 16'h3132, 16'h4142, 16'h5152, 16'h6162, 16'h7172};
      for (int i = 0; i < accel_rate_pkg::EXT_BYTES; i++) ext_bytes[8*i+:8] = 8'(8'h40 + i);
      slot0_len = 4'h2;
      slot1_len = 4'h3;
      slot2_len = 4'h1;
      err_count = 0;
      cmp_count = 0;
      tick(6);
      rst = 1'b0;
      t_regs();
      t_rates();
      t_frame(8'hff, 1'b1);
      t_frame(8'h88, 1'b0);
      t_frame(8'h52, 1'b1);
      t_frame(8'h00, 1'b0);
      lin_filter_bypass = 1'b1;
      sample_divider = 8'h00;
      wr(accel_rate_pkg::OFS_WAKE_LEVEL, 8'h02);
      t_wom(16'h0083, 16'h0000, 1'b1);
      t_wom(16'h0000, 16'h0082, 1'b0);
      t_wom(16'hff7d, 16'h0000, 1'b1);
      t_wom(16'h0000, 16'h0000, 1'b0);
      final_report();
   end
endmodule
